// ---- design/irq_collector_defs.svh ----
// register offsets, field positions and reset values of the interrupt collector
`ifndef IRQ_COLLECTOR_DEFS_SVH
`define IRQ_COLLECTOR_DEFS_SVH
`define OFS_ENABLE_CPU0 8'h00
`define OFS_ENABLE_CPU1 8'h04
`define OFS_ENABLE_CPU2 8'h08
`define OFS_ENABLE_CPU3 8'h0C
`define OFS_ENABLE_BCAST 8'h10
`define OFS_PENDING 8'h14
`define OFS_SWI_SET 8'h18
`define OFS_SWI_CLEAR 8'h1C
`define OFS_EDGE_CLEAR 8'h20
`define OFS_EDGE_STATE 8'h24
`define OFS_UTILITY 8'h28
`define BIT_ABORT 31
`define BIT_POWER_FAIL 30
`define BIT_ARB_TIMEOUT 29
`define BIT_UART_TIMER 28
`define BIT_SWI_HI_TOP 27
`define BIT_SWI_HI_LOW 24
`define BIT_IRQ7 23
`define BIT_COUNTER_CHIP 21
`define BIT_SYSTEM_FAIL 20
`define BIT_IRQ6 19
`define CLR_ABORT 2
`define CLR_POWER_FAIL 1
`define CLR_SYSTEM_FAIL 0
`define UTIL_ARB_TO_EN 5
`define UTIL_WDOG_EN 2
`define RESET_ENABLE 32'h0000_0000
`define RESET_SWI 8'h00
`define UNDEF_READ 32'hFFFF_FFFF
`define SRC_IDLE 8'h7A
`endif

// ---- design/irq_collector_pkg.sv ----
// types of the interrupt collector
package irq_collector_pkg;
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } bus_req_t;
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } bus_rsp_t;
    typedef struct packed {
        logic abortPressed;
        logic powerFailN;
        logic systemFailN;
        logic irq7N;
        logic irq6N;
        logic arbTimeout;
        logic uartTimerN;
        logic counterChipIrq;
    } irq_src_t;
    typedef enum logic [1:0] {IDLE, ANSWER} bus_state_t;
endpackage : irq_collector_pkg

// ---- design/board_interrupt_collector.sv ----
// interrupt collection block with avalon-mm register slave
// How it works
// RQ1: every register sits on its own aligned 32-bit word.
// RQ2: software uses whole 32-bit accesses; byte enables are not decoded.
// RQ3: undefined bits and unmapped words read as ones; writes there ignored.
// RQ4: pending status shows every request, whatever the masks hold.
// RQ5: four read/write enable masks, one per processor, status layout.
// RQ6: system or local reset clears all four enable masks.
// RQ7: reset does not force status; level bits follow their sources.
// RQ8: reserved status and enable positions, bits 22 and 18 too, read zero.
// RQ9: broadcast write loads the same value into all four masks.
// RQ10: bit 31 sets on abort press, stays until abort clear written.
// RQ11: bit 30 latches on power-fail assertion until its clear is written.
// RQ12: bit 29 sets on arbiter grant timeout once timeout enable is set.
// RQ13: bit 28 is one while the serial timer output is low.
// RQ14: bits 27..24 show software requests; resets clear them.
// RQ15: bits 23 and 19 follow backplane levels seven and six, unlatched.
// RQ16: bit 21 is one while the counter chip requests.
// RQ17: bit 20 latches on system-fail assertion until its clear is written.
// RQ18: software sets serial output 3 up as counter-ready output.
// RQ19: counter chip reset follows system or local reset.
// RQ20: counter timer 3 output drives watchdog when watchdog enable set.
// RQ21: abort, power-fail and system-fail set only on inactive-to-active.
// RQ22: edge clear resets written-one requests; re-arm needs a new edge.
// RQ23: software set location sets written-one bits, zeros unchanged.
// RQ24: a processor's interrupt is high when status and its mask overlap.
// RQ25: outside inputs pass two flip-flops before any use.
`include "irq_collector_defs.svh"
module board_interrupt_collector #(
    parameter int CPUS = 4
) (
    // clock and resets
    input wire logic clock,
    input wire logic rstn,
    input wire logic systemResetN,
    input wire logic localResetN,
    // avalon-mm slave
    input wire irq_collector_pkg::bus_req_t busReq,
    output irq_collector_pkg::bus_rsp_t busRsp,
    // interrupt sources
    input wire irq_collector_pkg::irq_src_t irqSrc,
    input wire logic timer3Output,
    // outputs
    output logic [CPUS-1:0] cpuIrq,
    output logic counterChipResetN,
    output logic watchdogTick
);
    import irq_collector_pkg::*;

    // resets are pins, so synchronise them too
    logic [1:0] sysRstSync_q;
    logic [1:0] locRstSync_q;
    logic [1:0] tmr3Sync_q;
    irq_src_t srcMeta_q;
    irq_src_t src_q;
    irq_src_t srcPrev_q;
    logic [31:0] enable_q [CPUS];
    logic [7:0] softwareIrq_q;
    logic abortEdge_q;
    logic powerFailEdge_q;
    logic systemFailEdge_q;
    logic arbTimeoutFlag_q;
    logic arbTimeoutEnable_q;
    logic watchdogEnable_q;
    bus_state_t state_q;
    logic [31:0] readData_q;
    logic waitReq_q;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sysRstSync_q <= 2'h0;
            locRstSync_q <= 2'h0;
            tmr3Sync_q <= 2'h0;
        end
        else
        begin
            sysRstSync_q <= {sysRstSync_q[0], systemResetN}; // [RQ25]
            locRstSync_q <= {locRstSync_q[0], localResetN}; // [RQ25]
            tmr3Sync_q <= {tmr3Sync_q[0], timer3Output}; // [RQ25]
        end
    end

    // sources start at their idle levels, so pending shows nothing at reset
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            srcMeta_q <= `SRC_IDLE;
            src_q <= `SRC_IDLE;
        end
        else
        begin
            srcMeta_q <= irqSrc; // [RQ25]
            src_q <= srcMeta_q; // [RQ25]
        end
    end

    wire boardReset = !sysRstSync_q[1] || !locRstSync_q[1];

    // active levels of the synchronised sources
    wire abortActive = src_q.abortPressed;
    wire powerFailActive = !src_q.powerFailN;
    wire systemFailActive = !src_q.systemFailN;
    wire abortRise = abortActive && !srcPrev_q.abortPressed; // [RQ21]
    wire powerFailRise = powerFailActive && srcPrev_q.powerFailN; // [RQ21]
    wire systemFailRise = systemFailActive && srcPrev_q.systemFailN; // [RQ21]
    wire arbTimeoutRise = src_q.arbTimeout && !srcPrev_q.arbTimeout;

    // bus decode
    // a write takes effect at the edge that takes the request
    wire accessStart = (state_q == IDLE) && (busReq.read || busReq.write);
    wire wrStrobe = accessStart && busReq.write;
    wire [7:0] addr = busReq.address;
    wire [31:0] wdata = busReq.writedata;
    wire wrBcast = wrStrobe && addr == `OFS_ENABLE_BCAST; // [RQ9]
    wire wrSwiSet = wrStrobe && addr == `OFS_SWI_SET;
    wire wrSwiClr = wrStrobe && addr == `OFS_SWI_CLEAR;
    wire wrEdgeClr = wrStrobe && addr == `OFS_EDGE_CLEAR;
    wire wrUtil = wrStrobe && addr == `OFS_UTILITY;
    wire clrAbort = wrEdgeClr && wdata[`CLR_ABORT]; // [RQ22]
    wire clrPowerFail = wrEdgeClr && wdata[`CLR_POWER_FAIL]; // [RQ22]
    wire clrSystemFail = wrEdgeClr && wdata[`CLR_SYSTEM_FAIL]; // [RQ22]
    wire [7:0] swiSetBits = wrSwiSet ? wdata[7:0] : 8'h00;
    wire [7:0] swiClrBits = wrSwiClr ? wdata[7:0] : 8'h00;

    // no reset of its own: level bits follow their sources [RQ7]
    // pending status word; unassigned positions stay zero [RQ8]
    logic [31:0] pending;
    always_comb
    begin
        pending = 32'h0000_0000;
        pending[`BIT_ABORT] = abortEdge_q; // [RQ10]
        pending[`BIT_POWER_FAIL] = powerFailEdge_q; // [RQ11]
        pending[`BIT_ARB_TIMEOUT] = arbTimeoutFlag_q; // [RQ12]
        pending[`BIT_UART_TIMER] = !src_q.uartTimerN; // [RQ13]
        pending[`BIT_SWI_HI_TOP:`BIT_SWI_HI_LOW] = softwareIrq_q[7:4]; // [RQ14]
        pending[`BIT_IRQ7] = !src_q.irq7N; // [RQ15]
        pending[`BIT_COUNTER_CHIP] = src_q.counterChipIrq; // [RQ16]
        pending[`BIT_SYSTEM_FAIL] = systemFailEdge_q; // [RQ17]
        pending[`BIT_IRQ6] = !src_q.irq6N; // [RQ15]
        pending[3:0] = softwareIrq_q[3:0];
    end
    // only implemented status positions may be enabled
    wire [31:0] statusMask = 32'hFFB8_000F; // [RQ8]

    // next values of the edge requests: a set wins over a clear
    wire abortEdge_d = abortRise || (abortEdge_q && !clrAbort); // [RQ10]
    wire powerFailEdge_d = powerFailRise
        || (powerFailEdge_q && !clrPowerFail); // [RQ11]
    wire systemFailEdge_d = systemFailRise
        || (systemFailEdge_q && !clrSystemFail); // [RQ17]
    // rewriting the enable to one restarts the flag
    wire arbTimeoutClear = wrUtil && wdata[`UTIL_ARB_TO_EN];
    wire arbTimeoutFlag_d = (arbTimeoutEnable_q && arbTimeoutRise)
        || (arbTimeoutFlag_q && !arbTimeoutClear); // [RQ12]

    // previous sample starts idle too, so reset release makes no edge
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            srcPrev_q <= `SRC_IDLE;
        else
            srcPrev_q <= src_q; // [RQ21]
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            abortEdge_q <= 1'b0;
        else if (boardReset)
            abortEdge_q <= 1'b0;
        else
            abortEdge_q <= abortEdge_d;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            powerFailEdge_q <= 1'b0;
        else if (boardReset)
            powerFailEdge_q <= 1'b0;
        else
            powerFailEdge_q <= powerFailEdge_d;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            systemFailEdge_q <= 1'b0;
        else if (boardReset)
            systemFailEdge_q <= 1'b0;
        else
            systemFailEdge_q <= systemFailEdge_d;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            arbTimeoutFlag_q <= 1'b0;
        else if (boardReset)
            arbTimeoutFlag_q <= 1'b0;
        else
            arbTimeoutFlag_q <= arbTimeoutFlag_d;
    end

    // software requests: set wins over clear
    wire [7:0] softwareIrq_d = swiSetBits
        | (softwareIrq_q & ~swiClrBits); // [RQ23]
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            softwareIrq_q <= `RESET_SWI;
        else if (boardReset)
            softwareIrq_q <= `RESET_SWI; // [RQ14]
        else
            softwareIrq_q <= softwareIrq_d;
    end

    // utility control bits; board reset clears both, like the masks
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            arbTimeoutEnable_q <= 1'b0;
        else if (boardReset)
            arbTimeoutEnable_q <= 1'b0;
        else if (wrUtil)
            arbTimeoutEnable_q <= wdata[`UTIL_ARB_TO_EN];
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            watchdogEnable_q <= 1'b0;
        else if (boardReset)
            watchdogEnable_q <= 1'b0;
        else if (wrUtil)
            watchdogEnable_q <= wdata[`UTIL_WDOG_EN];
    end

    // per-processor masks and interrupt outputs
    // masks keep implemented positions only, so reserved bits read zero
    genvar c;
    generate
        for (c = 0; c < CPUS; c++)
        begin : g_cpu
            wire [7:0] myOfs = `OFS_ENABLE_CPU0 + 8'(c * 4);
            wire wrMine = wrStrobe && addr == myOfs; // [RQ1]
            always_ff @(posedge clock or negedge rstn)
            begin
                if (!rstn)
                    enable_q[c] <= `RESET_ENABLE;
                else if (boardReset)
                    enable_q[c] <= `RESET_ENABLE; // [RQ6]
                else if (wrMine || wrBcast)
                    enable_q[c] <= wdata & statusMask; // [RQ5] [RQ9]
            end
            always_ff @(posedge clock or negedge rstn)
            begin
                if (!rstn)
                    cpuIrq[c] <= 1'b0;
                else
                    cpuIrq[c] <= |(pending & enable_q[c]); // [RQ24]
            end
        end
    endgenerate

    // read mux; unmapped words read as ones
    // write-only locations fall to the default and read ones as well
    logic [31:0] readMux;
    always_comb
    begin
        case (addr)
            `OFS_ENABLE_CPU0: readMux = enable_q[0];
            `OFS_ENABLE_CPU1: readMux = enable_q[1];
            `OFS_ENABLE_CPU2: readMux = enable_q[2];
            `OFS_ENABLE_CPU3: readMux = enable_q[3];
            `OFS_PENDING: readMux = pending; // [RQ4]
            `OFS_EDGE_STATE: readMux = {29'h1FFF_FFFF, abortActive,
                powerFailActive, systemFailActive}; // [RQ3]
            `OFS_UTILITY: readMux = {26'h3FF_FFFF, arbTimeoutEnable_q,
                2'h3, watchdogEnable_q, 2'h3}; // [RQ3]
            default: readMux = `UNDEF_READ; // [RQ3]
        endcase
    end

    // one wait cycle per access: answer registered the cycle after
    // one access every two cycles at best; the host waits for the answer
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= IDLE;
            readData_q <= 32'h0000_0000;
            waitReq_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                IDLE:
                begin
                    waitReq_q <= 1'b1;
                    if (accessStart)
                    begin
                        state_q <= ANSWER;
                        readData_q <= busReq.read ? readMux : 32'h0000_0000;
                        waitReq_q <= 1'b0;
                    end
                end
                ANSWER:
                begin
                    state_q <= IDLE;
                    waitReq_q <= 1'b1;
                end
                default:
                begin
                    state_q <= IDLE;
                    waitReq_q <= 1'b1;
                end
            endcase
        end
    end
    assign busRsp.readdata = readData_q;
    assign busRsp.waitrequest = waitReq_q;

    // chip reset also follows rstn, so the chip never runs half reset
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            counterChipResetN <= 1'b0;
        else
            counterChipResetN <= !boardReset; // [RQ19]
    end

    // watchdog sees the synchronised timer only while enabled
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            watchdogTick <= 1'b0;
        else
            watchdogTick <= tmr3Sync_q[1] && watchdogEnable_q; // [RQ20]
    end
endmodule : board_interrupt_collector

// ---- tb/host_model.sv ----
// avalon-mm master standing for the local processors
module host_model (
    // clock
    input wire logic clock,
    // bus
    output irq_collector_pkg::bus_req_t busReq,
    input wire irq_collector_pkg::bus_rsp_t busRsp
);
    timeunit 1ns;
    timeprecision 1ns;
    import irq_collector_pkg::*;
    initial busReq = '0;
    // whole words only, since byte lanes are not decoded
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        busReq <= '{a, !w, w, d};
        do @(posedge clock); while (busRsp.waitrequest !== 1'b0);
        q = busRsp.readdata;
        busReq <= '0;
    endtask : xfer
endmodule : host_model

// ---- tb/irq_collector_chk.sv ----
// port assertions of the interrupt collector
module irq_collector_chk #(
    parameter int CPUS = 4
) (
    // clock and resets
    input wire logic clock,
    input wire logic rstn,
    input wire logic systemResetN,
    input wire logic localResetN,
    // bus
    input wire irq_collector_pkg::bus_req_t busReq,
    input wire irq_collector_pkg::bus_rsp_t busRsp,
    // sources
    input wire irq_collector_pkg::irq_src_t irqSrc,
    input wire logic timer3Output,
    // outputs
    input wire logic [CPUS-1:0] cpuIrq,
    input wire logic counterChipResetN,
    input wire logic watchdogTick
);
    timeunit 1ns;
    timeprecision 1ns;
    import irq_collector_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    wire answer = !busRsp.waitrequest && busReq.read;
    wire boardRst = !(systemResetN && localResetN);
    sequence s_read_of(logic [7:0] a);
        answer && busReq.address == a;
    endsequence
    // six cycles covers the two sync stages and the read register
    sequence s_irq7_held;
        (!irqSrc.irq7N)[*6];
    endsequence
    AST_ANSWER_NEXT: assert property (
        $rose(busReq.read) |=> !busRsp.waitrequest)
        else $error("bus answer missing");
    AST_ANSWER_ONE: assert property (
        !busRsp.waitrequest |=> busRsp.waitrequest)
        else $error("answer longer than one cycle");
    AST_UNMAPPED: assert property (
        answer && busReq.address > 8'h28 |->
        busRsp.readdata == 32'hFFFF_FFFF)
        else $error("unmapped read not all ones");
    AST_RESERVED: assert property (
        s_read_of(8'h14) |-> !busRsp.readdata[22] && !busRsp.readdata[18])
        else $error("reserved status bit set");
    AST_IRQ7_LEVEL: assert property (
        s_irq7_held ##0 s_read_of(8'h14) |-> busRsp.readdata[23])
        else $error("level seven not shown");
    AST_CHIP_RESET: assert property (
        boardRst[*5] |-> !counterChipResetN)
        else $error("counter chip not held in reset");
    AST_MASK_CLEAR: assert property (
        boardRst[*5] |-> cpuIrq == '0)
        else $error("interrupt out during board reset");
    AST_WDOG_OFF: assert property (
        (!timer3Output)[*5] |-> !watchdogTick)
        else $error("watchdog tick without timer");
endmodule : irq_collector_chk
bind board_interrupt_collector irq_collector_chk #(.CPUS(CPUS)) chk_i (
    .clock(clock), .rstn(rstn), .systemResetN(systemResetN),
    .localResetN(localResetN), .busReq(busReq), .busRsp(busRsp),
    .irqSrc(irqSrc), .timer3Output(timer3Output), .cpuIrq(cpuIrq),
    .counterChipResetN(counterChipResetN), .watchdogTick(watchdogTick));

// ---- tb/tb.sv ----
// self-checking bench of the interrupt collector
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import irq_collector_pkg::*;
    typedef struct {logic [7:0] wa; logic [31:0] wd;
        logic [7:0] ra; logic [31:0] ex;} row_t;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic systemResetN = 1'b1;
    logic localResetN = 1'b1;
    bus_req_t busReq;
    bus_rsp_t busRsp;
    // sources idle: lows high, abort and requests off
    // uartTimerN stands for serial output 3 set up as counter-ready
    irq_src_t irqSrc = 8'h7A;
    logic timer3Output = 1'b0;
    logic [3:0] cpuIrq;
    logic counterChipResetN;
    logic watchdogTick;
    logic [31:0] got;
    int error_cnt = 0;
    int samples_checked = 0;
    row_t rows[8] = '{
        '{8'h00, 32'hFFFF_FFFF, 8'h00, 32'hFFB8_000F},
        '{8'h04, 32'h0000_1234, 8'h04, 32'h0000_0004},
        '{8'h10, 32'h0080_0000, 8'h08, 32'h0080_0000},
        '{8'hFC, 32'h0000_0000, 8'h10, 32'hFFFF_FFFF},
        '{8'h18, 32'h0000_0081, 8'h14, 32'h0800_0001},
        '{8'h1C, 32'h0000_0080, 8'h14, 32'h0000_0001},
        '{8'h14, 32'hFFFF_FFFF, 8'h00, 32'h0080_0000},
        '{8'h2C, 32'hFFFF_FFFF, 8'hFC, 32'hFFFF_FFFF}};
    board_interrupt_collector #(.CPUS(4)) uut (.clock(clock), .rstn(rstn),
        .systemResetN(systemResetN), .localResetN(localResetN),
        .busReq(busReq), .busRsp(busRsp), .irqSrc(irqSrc),
        .timer3Output(timer3Output), .cpuIrq(cpuIrq),
        .counterChipResetN(counterChipResetN), .watchdogTick(watchdogTick));
    host_model host (.clock(clock), .busReq(busReq), .busRsp(busRsp));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, got);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0000_0000, got);
        chk(got, e);
    endtask : rd
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    initial
        forever #5 clock = ~clock;
    initial
    begin
        #100000;
        error_cnt++;
        summarize();
    end
    initial
    begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        repeat (5) @(posedge clock);
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, rows[i].ex);
        end
        $display("test table done");
        irqSrc <= 8'h61;
        repeat (6) @(posedge clock);
        rd(8'h14, 32'h10A8_0001);
        chk({28'h0, cpuIrq}, 32'h0000_000F);
        wr(8'h04, 32'h0000_0000);
        repeat (3) @(posedge clock);
        chk({28'h0, cpuIrq}, 32'h0000_000D);
        irqSrc <= 8'h7A;
        repeat (6) @(posedge clock);
        chk({28'h0, cpuIrq}, 32'h0000_0000);
        $display("test levels done");
        irqSrc <= 8'h9A;
        repeat (6) @(posedge clock);
        // system-fail stays low so a clear must not re-arm it
        irqSrc <= 8'h5A;
        repeat (6) @(posedge clock);
        rd(8'h14, 32'hC010_0001);
        rd(8'h24, 32'hFFFF_FFF9);
        wr(8'h20, 32'h0000_0004);
        rd(8'h14, 32'h4010_0001);
        wr(8'h20, 32'h0000_0007);
        rd(8'h14, 32'h0000_0001);
        irqSrc <= 8'h7A;
        repeat (6) @(posedge clock);
        // a fresh system-fail edge after the clear sets the request again
        irqSrc <= 8'h5A;
        repeat (6) @(posedge clock);
        rd(8'h14, 32'h0010_0001);
        wr(8'h20, 32'h0000_0001);
        irqSrc <= 8'h7A;
        repeat (6) @(posedge clock);
        rd(8'h14, 32'h0000_0001);
        $display("test edges done");
        irqSrc <= 8'h7E;
        repeat (4) @(posedge clock);
        irqSrc <= 8'h7A;
        rd(8'h14, 32'h0000_0001);
        wr(8'h28, 32'h0000_0024);
        timer3Output <= 1'b1;
        irqSrc <= 8'h7E;
        repeat (6) @(posedge clock);
        rd(8'h14, 32'h2000_0001);
        chk({31'h0, watchdogTick}, 32'h0000_0001);
        irqSrc <= 8'h7A;
        wr(8'h28, 32'h0000_0024);
        rd(8'h14, 32'h0000_0001);
        $display("test timeout done");
        // level seven held low across the reset
        irqSrc <= 8'h6A;
        localResetN <= 1'b0;
        repeat (6) @(posedge clock);
        chk({31'h0, counterChipResetN}, 32'h0000_0000);
        localResetN <= 1'b1;
        repeat (6) @(posedge clock);
        chk({31'h0, counterChipResetN}, 32'h0000_0001);
        rd(8'h00, 32'h0000_0000);
        rd(8'h14, 32'h0080_0000);
        chk({31'h0, watchdogTick}, 32'h0000_0000);
        $display("test reset done");
        summarize();
    end
endmodule : tb
